// *** fet_mux_switch_control.sv ***
// Behaviour
// - register 0 read gives id, upper byte ones
// - id: five component bits, three terminal bits
// - no terminal module forces low bits ones
// - register 1 read shows pacing status
// - register 2 shows switch state bits 0-11
// - bits 8-11 tree switches, one is closed
// - bank nibbles hold decimal channel or 1111
// - bank b decoded one decade above a
// - register 0 write opens all, stops strobes
// - register 3 command opens, pulses open strobe
// - register 4 write opens relays, pulses open
// - register 5 closes relays after open strobe
// - pulse close strobe while relays close
// - register 6 command closes, pulses close strobe
// - one command format, register picks action
// - bit 15 relays; 14-12 enable nibbles
// - tree bits 11..8 map channels 94..91
// - each enabled bank nibble decoded independently
// - relays stay closed until open or reset

`include "fet_mux_consts.svh"

`timescale 1ns/1ns
`default_nettype none

module fet_mux_switch_control
    import fet_mux_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire reg_req_t req,
    output logic [15:0] rd_data,
    input wire logic bp_reset,
    input wire logic [2:0] term_id,
    input wire logic term_absent,
    input wire logic opening_i,
    output logic opening_o,
    output logic opening_oe,
    output logic closing_o,
    output logic [9:0] bank_a_sw,
    output logic [9:0] bank_b_sw,
    output logic [3:0] tree_sw,
    output logic relay_closed
);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // reset pin, opening line and terminal straps are all asynchronous
    // only the second stage is read; the first may still be settling
    logic [5:0] pins_meta_q;
    logic [5:0] pins_q;
    wire [5:0] pins_raw = {bp_reset, opening_i, term_absent, term_id};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pins_meta_q <= 6'h00;
            pins_q <= 6'h00;
        end else begin
            pins_meta_q <= pins_raw;
            pins_q <= pins_meta_q;
        end
    end

    wire bp_reset_s = pins_q[5];
    wire opening_line_s = pins_q[4];
    wire term_absent_s = pins_q[3];
    wire [2:0] term_id_s = pins_q[2:0];

    // ----------------------------------------
    // write decode
    // ----------------------------------------
    wire cmd_word_t cmd = cmd_word_t'(req.data[15:0]);
    // writes to 1, 2 and 7 match nothing here and are dropped
    wire wr_reset = req.wr && (req.addr == `REG_RESET_TRIGGER);
    wire wr_open_cmd = req.wr && (req.addr == `REG_OPEN_CMD);
    wire wr_relay_open = req.wr && (req.addr == `REG_RELAY_OPEN);
    wire wr_relay_close = req.wr && (req.addr == `REG_RELAY_CLOSE);
    wire wr_close_cmd = req.wr && (req.addr == `REG_CLOSE_CMD);

    // backplane reset and a register 0 write act identically
    wire clear_all = wr_reset || bp_reset_s;

    // bit 15 acts on the relays when register 3 or 6 takes the word; 4 and 5 act on the relays whatever it holds
    wire relay_open_req = wr_relay_open || (wr_open_cmd && cmd.relay);
    wire relay_close_req = wr_relay_close || (wr_close_cmd && cmd.relay);

    // ----------------------------------------
    // switch state
    // ----------------------------------------
    logic [3:0] bank_a_q;
    logic [3:0] bank_b_q;
    logic [3:0] tree_q;
    logic [3:0] bank_a_d;
    logic [3:0] bank_b_d;
    logic [3:0] tree_d;

    // only one channel per bank can be closed, so the state is a code
    function automatic logic [3:0] bank_next(
        input logic [3:0] cur,
        input logic [3:0] code,
        input logic en,
        input logic close
    );
        logic [3:0] res;
        res = cur;
        if (en && code <= `BANK_MAX_CODE) begin
            if (close) begin
                res = code;
            end else if (cur == code) begin
                res = `BANK_ALL_OPEN;
            end
        end
        return res;
    endfunction : bank_next

    // address alone picks open or close for the same word layout
    wire do_cmd = wr_open_cmd || wr_close_cmd;
    wire cmd_close = wr_close_cmd;

    always_comb begin
        bank_a_d = bank_a_q;
        bank_b_d = bank_b_q;
        tree_d = tree_q;
        // a clear in the same cycle as a command wins
        if (clear_all) begin
            bank_a_d = `BANK_ALL_OPEN;
            bank_b_d = `BANK_ALL_OPEN;
            tree_d = 4'h0;
        end else if (do_cmd) begin
            bank_a_d = bank_next(bank_a_q, cmd.bank_a, cmd.bank_a_en, cmd_close);
            bank_b_d = bank_next(bank_b_q, cmd.bank_b, cmd.bank_b_en, cmd_close);
            if (cmd.tree_en) begin
                tree_d = cmd_close ? (tree_q | cmd.tree) : (tree_q & ~cmd.tree);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bank_a_q <= `BANK_ALL_OPEN;
            bank_b_q <= `BANK_ALL_OPEN;
            tree_q <= 4'h0;
        end else begin
            bank_a_q <= bank_a_d;
            bank_b_q <= bank_b_d;
            tree_q <= tree_d;
        end
    end

    // ----------------------------------------
    // switch drive outputs
    // ----------------------------------------
    // index i of bank b is channel 10 + i
    // outputs decode the next code so they move with the state
    genvar gi;
    generate
        for (gi = 0; gi < 10; gi++) begin : g_chan
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    bank_a_sw[gi] <= 1'b0;
                    bank_b_sw[gi] <= 1'b0;
                end else begin
                    bank_a_sw[gi] <= (bank_a_d == 4'(gi));
                    bank_b_sw[gi] <= (bank_b_d == 4'(gi));
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tree_sw <= 4'h0;
        end else begin
            tree_sw <= tree_d;
        end
    end

    // ----------------------------------------
    // opening strobe
    // ----------------------------------------
    logic [7:0] open_cnt_q;
    logic opening_drive_q;
    wire start_open = wr_open_cmd || wr_relay_open;
    // high from the launch edge until the count reaches one: exactly the count long
    wire opening_drive_d = !clear_all && (start_open || open_cnt_q > 8'h01);

    // a new launch restarts the count and so stretches a running pulse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            open_cnt_q <= 8'h00;
        end else if (clear_all) begin
            open_cnt_q <= 8'h00;
        end else if (start_open) begin
            open_cnt_q <= 8'(`OPEN_PULSE_CYC);
        end else if (open_cnt_q != 8'h00) begin
            open_cnt_q <= open_cnt_q - 8'h01;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            opening_drive_q <= 1'b0;
        end else begin
            opening_drive_q <= opening_drive_d;
        end
    end

    assign opening_o = opening_drive_q;
    assign opening_oe = opening_drive_q;

    // another card may hold the line too, so both are watched
    // our own drive returns on the line late, which only stretches busy
    wire opening_busy = opening_drive_q || opening_line_s;

    // a FET opening launched on this very edge must hold the make off too
    wire hold_close = opening_busy || start_open;

    // ----------------------------------------
    // isolation relays
    // ----------------------------------------
    relay_state_t relay_q;
    relay_state_t relay_d;
    logic relay_fire;

    always_comb begin
        relay_d = relay_q;
        relay_fire = 1'b0;
        if (clear_all) begin
            relay_d = RELAY_OPEN;
        end else if (relay_open_req) begin
            // an open beats a close that is still waiting
            relay_d = RELAY_OPEN;
        end else begin
            case (relay_q)
                RELAY_OPEN: begin
                    if (relay_close_req) begin
                        relay_d = RELAY_WAIT;
                    end
                end
                RELAY_WAIT: begin
                    // break before make
                    if (!hold_close) begin
                        relay_d = RELAY_CLOSED;
                        relay_fire = 1'b1;
                    end
                end
                RELAY_CLOSED: begin
                    // a repeated close request makes no second close pulse
                    relay_d = RELAY_CLOSED;
                end
                default: begin
                    relay_d = RELAY_OPEN;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            relay_q <= RELAY_OPEN;
            relay_closed <= 1'b0;
        end else begin
            relay_q <= relay_d;
            relay_closed <= (relay_d == RELAY_CLOSED);
        end
    end

    // ----------------------------------------
    // closing strobe
    // ----------------------------------------
    logic [7:0] close_cnt_q;
    wire start_close = wr_close_cmd || relay_fire;
    // same shape as the opening drive
    wire closing_d = !clear_all && (start_close || close_cnt_q > 8'h01);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            close_cnt_q <= 8'h00;
        end else if (clear_all) begin
            close_cnt_q <= 8'h00;
        end else if (start_close) begin
            close_cnt_q <= 8'(`CLOSE_PULSE_CYC);
        end else if (close_cnt_q != 8'h00) begin
            close_cnt_q <= close_cnt_q - 8'h01;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            closing_o <= 1'b0;
        end else begin
            closing_o <= closing_d;
        end
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    wire [2:0] term_code = term_absent_s ? `NO_TERMINAL_CODE : term_id_s;
    wire [15:0] id_word = {`ID_UPPER_FILL, `COMPONENT_TYPE, term_code};

    // ----------------------------------------
    // status
    // ----------------------------------------
    // a close still waiting on the opening line shows here so the controller can pace
    logic [15:0] status_word;
    always_comb begin
        status_word = 16'h0000;
        status_word[`STAT_TERM_ABSENT] = term_absent_s;
        status_word[`STAT_OPENING_BUSY] = opening_busy;
        status_word[`STAT_CLOSING_BUSY] = closing_o;
        status_word[`STAT_RELAY_PENDING] = (relay_q == RELAY_WAIT);
        status_word[`STAT_RELAY_CLOSED] = relay_closed;
    end

    // undefined top nibble is returned as zero
    wire [15:0] switch_word = {4'h0, tree_q, bank_b_q, bank_a_q};

    // ----------------------------------------
    // read select
    // ----------------------------------------
    // registers 3 to 7 read as zero
    wire rd_id = req.addr == `REG_IDENTITY;
    wire rd_status = req.addr == `REG_STATUS;
    wire rd_switch = req.addr == `REG_SWITCH_STATE;
    wire [15:0] rd_sel = rd_id ? id_word :
                         rd_status ? status_word :
                         rd_switch ? switch_word : 16'h0000;

    // answer held until the next read
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data <= 16'h0000;
        end else if (req.rd) begin
            rd_data <= rd_sel;
        end
    end

endmodule : fet_mux_switch_control

`default_nettype wire

// *** fet_mux_consts.svh ***
`ifndef FET_MUX_CONSTS_SVH
`define FET_MUX_CONSTS_SVH

// ----------------------------------------
// register numbers
// ----------------------------------------
`define REG_IDENTITY 3'h0
`define REG_RESET_TRIGGER 3'h0
`define REG_STATUS 3'h1
`define REG_SWITCH_STATE 3'h2
`define REG_OPEN_CMD 3'h3
`define REG_RELAY_OPEN 3'h4
`define REG_RELAY_CLOSE 3'h5
`define REG_CLOSE_CMD 3'h6

// ----------------------------------------
// identity and field layout
// ----------------------------------------
// component type value is arbitrary
`define COMPONENT_TYPE 5'h0b
`define ID_UPPER_FILL 8'hff
`define NO_TERMINAL_CODE 3'h7
`define BANK_ALL_OPEN 4'hf
`define BANK_MAX_CODE 4'h9
`define STAT_TERM_ABSENT 0
`define STAT_OPENING_BUSY 1
`define STAT_CLOSING_BUSY 2
`define STAT_RELAY_PENDING 3
`define STAT_RELAY_CLOSED 4

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define OPEN_PULSE_NS 500
`define CLOSE_PULSE_NS 500
`define OPEN_PULSE_CYC ((`OPEN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CLOSE_PULSE_CYC ((`CLOSE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** fet_mux_pkg.sv ***
`default_nettype none

package fet_mux_pkg;

    // one register access from the backplane controller
    typedef struct packed {
        logic rd;
        logic wr;
        logic [2:0] addr;
        logic [15:0] data;
    } reg_req_t;

    // shared layout of the open and close command words
    typedef struct packed {
        logic relay;
        logic tree_en;
        logic bank_b_en;
        logic bank_a_en;
        logic [3:0] tree;
        logic [3:0] bank_b;
        logic [3:0] bank_a;
    } cmd_word_t;

    typedef enum logic [1:0] {
        RELAY_OPEN,
        RELAY_WAIT,
        RELAY_CLOSED
    } relay_state_t;

endpackage : fet_mux_pkg

`default_nettype wire

// *** opening_line_model.sv ***
`timescale 1ns/1ns
`default_nettype none

module opening_line_model (
    input wire logic opening_o,
    input wire logic opening_oe,
    input wire logic other_hold,
    output logic opening_wire
);
    // wired-or line: another card may stretch the opening phase
    assign opening_wire = (opening_oe & opening_o) | other_hold;
endmodule : opening_line_model

`default_nettype wire

// *** fet_mux_monitor.sv ***
`include "fet_mux_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module fet_mux_monitor
    import fet_mux_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire reg_req_t req,
    input wire logic [15:0] rd_data,
    input wire logic bp_reset,
    input wire logic [2:0] term_id,
    input wire logic term_absent,
    input wire logic opening_i,
    input wire logic opening_o,
    input wire logic opening_oe,
    input wire logic closing_o,
    input wire logic [9:0] bank_a_sw,
    input wire logic [9:0] bank_b_sw,
    input wire logic [3:0] tree_sw,
    input wire logic relay_closed
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire logic cmd_wr = req.wr && (req.addr == 3'h3 || req.addr == 3'h6) && req.data[12];
    wire logic rel_open = req.wr && (req.addr == 3'h0 || req.addr == 3'h4 || (req.addr == 3'h3 && req.data[15]));

    AST_ID: assert property (req.rd && req.addr == 3'h0
        |=> rd_data[15:3] == {8'hff, `COMPONENT_TYPE}) else $error("identity read wrong");
    AST_STATE: assert property (req.rd && !req.wr && req.addr == 3'h2
        |=> rd_data[11:8] == $past(tree_sw)) else $error("tree state read wrong");
    AST_ONEHOT: assert property ($onehot0(bank_a_sw) && $onehot0(bank_b_sw))
        else $error("more than one bank channel closed");
    AST_CLEAR: assert property (req.wr && req.addr == 3'h0
        |=> !(|{bank_a_sw, bank_b_sw, tree_sw, relay_closed, closing_o, opening_oe}))
        else $error("reset write left something active");
    AST_OPEN: assert property (req.wr && (req.addr == 3'h3 || req.addr == 3'h4)
        |=> opening_oe && opening_o) else $error("opening strobe missing");
    AST_BREAK: assert property ($rose(relay_closed) |-> closing_o && !opening_oe && !$past(opening_oe))
        else $error("relay closed during opening or without closing strobe");
    AST_CLOSE: assert property (cmd_wr && req.addr == 3'h6 && req.data[3:0] <= 4'h9
        |=> closing_o && bank_a_sw == (10'h001 << $past(req.data[3:0])))
        else $error("close command not applied");
    AST_BAD: assert property (cmd_wr && req.data[3:0] > 4'h9 && !bp_reset
        |=> $stable(bank_a_sw)) else $error("bad bank code changed switches");
    AST_KEEP: assert property ($fell(relay_closed)
        |-> $past(rel_open) || $past(bp_reset, 2) || $past(bp_reset, 3) || $past(bp_reset, 4))
        else $error("relay opened without cause");
endmodule : fet_mux_monitor

bind fet_mux_switch_control fet_mux_monitor u_mon (.clk(clk), .rst(rst), .req(req), .rd_data(rd_data),
    .bp_reset(bp_reset), .term_id(term_id), .term_absent(term_absent), .opening_i(opening_i),
    .opening_o(opening_o), .opening_oe(opening_oe), .closing_o(closing_o), .bank_a_sw(bank_a_sw),
    .bank_b_sw(bank_b_sw), .tree_sw(tree_sw), .relay_closed(relay_closed));

`default_nettype wire

// *** fet_mux_switch_control_tb.sv ***
`include "fet_mux_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module fet_mux_switch_control_tb
    import fet_mux_pkg::*;
;
    logic clk, rst, bp_reset, term_absent, hold;
    logic [2:0] term_id;
    reg_req_t req;
    wire logic [15:0] rd_data;
    wire logic line, op_o, op_oe, closing_o, relay;
    wire logic [9:0] a_sw, b_sw;
    wire logic [3:0] t_sw;
    int error_cnt = 0;
    int checked = 0;
    int cyc = 0;
    int n;

    fet_mux_switch_control dut (.clk(clk), .rst(rst), .req(req), .rd_data(rd_data), .bp_reset(bp_reset),
        .term_id(term_id), .term_absent(term_absent), .opening_i(line), .opening_o(op_o), .opening_oe(op_oe),
        .closing_o(closing_o), .bank_a_sw(a_sw), .bank_b_sw(b_sw), .tree_sw(t_sw), .relay_closed(relay));
    opening_line_model partner (.opening_o(op_o), .opening_oe(op_oe), .other_hold(hold), .opening_wire(line));

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic end_sim();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic tick(int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick

    task automatic wr(logic [2:0] a, logic [15:0] d);
        @(posedge clk);
        #1 req = '{1'b0, 1'b1, a, d};
        tick(1);
        req.wr = 1'b0;
    endtask : wr

    task automatic rd(logic [2:0] a);
        @(posedge clk);
        #1 req = '{1'b1, 1'b0, a, 16'h0000};
        tick(1);
        req.rd = 1'b0;
    endtask : rd

    // strobes restart on a new command, so width is measured from the launch
    task automatic pulse_len(logic sel);
        n = 0;
        while ((sel ? closing_o : op_oe) === 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
    endtask : pulse_len

    // closure lags the line by the input synchroniser
    task automatic wait_relay();
        n = 0;
        while (relay !== 1'b1 && n < 80) begin
            tick(1);
            n++;
        end
    endtask : wait_relay

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            end_sim();
        end
    end

    initial begin
        rst = 1'b1;
        bp_reset = 1'b0;
        term_absent = 1'b0;
        hold = 1'b0;
        term_id = 3'h5;
        req = '0;
        tick(20);
        rst = 1'b0;
        tick(2);
        rd(3'h0);
        check("identity", rd_data, {8'hff, `COMPONENT_TYPE, 3'h5});
        term_absent = 1'b1;
        tick(3);
        rd(3'h0);
        check("no terminal", rd_data, {8'hff, `COMPONENT_TYPE, 3'h7});
        rd(3'h1);
        check("status", 16'(rd_data[0]), 16'h0001);
        rd(3'h2);
        check("idle state", rd_data, 16'h00ff);
        rd(3'h3);
        check("unmapped", rd_data, 16'h0000);
        for (int i = 0; i < 10; i++) begin
            wr(3'h6, 16'h3000 | 16'(i * 17));
            check("bank a", 16'(a_sw), 16'(1 << i));
            check("bank b", 16'(b_sw), 16'(1 << i));
            check("closing", 16'(closing_o), 16'h0001);
            rd(3'h2);
            check("bank codes", rd_data, 16'(i * 17));
        end
        wr(3'h6, 16'h100c);
        check("bad code", 16'(a_sw), 16'h0200);
        wr(3'h6, 16'h4a00);
        rd(3'h2);
        check("tree state", rd_data, 16'h0a99);
        wr(3'h3, 16'h5809);
        check("tree open", 16'(t_sw), 16'h0002);
        check("bank a open", 16'(a_sw), 16'h0000);
        check("bank b kept", 16'(b_sw), 16'h0200);
        pulse_len(1'b0);
        check("opening width", 16'(n), 16'(`OPEN_PULSE_CYC));
        wr(3'h4, 16'h0000);
        check("relay open pulse", 16'({op_o, op_oe, relay}), 16'h0006);
        wr(3'h5, 16'h0000);
        pulse_len(1'b0);
        check("relay held", 16'(relay), 16'h0000);
        wait_relay();
        check("closing at closure", 16'({relay, closing_o}), 16'h0003);
        pulse_len(1'b1);
        check("closing width", 16'(n), 16'(`CLOSE_PULSE_CYC));
        wr(3'h4, 16'h0000);
        hold = 1'b1;
        wr(3'h5, 16'h0000);
        tick(80);
        check("held by line", 16'(relay), 16'h0000);
        rd(3'h1);
        check("status pending", rd_data, 16'h000b);
        hold = 1'b0;
        tick(1);
        wr(3'h3, 16'h0000);
        check("held by launch", 16'(relay), 16'h0000);
        wait_relay();
        check("closed after line", 16'(relay), 16'h0001);
        rd(3'h1);
        check("status closed", rd_data, 16'h0015);
        wr(3'h6, 16'h1001);
        wr(3'h3, 16'h1001);
        check("relay stays", 16'(relay), 16'h0001);
        wr(3'h3, 16'h8000);
        check("relay bit opens", 16'(relay), 16'h0000);
        wr(3'h6, 16'h8000);
        wait_relay();
        check("relay bit closes", 16'(relay), 16'h0001);
        wr(3'h6, 16'h7355);
        wr(3'h0, 16'ha5a5);
        check("reset banks", 16'(a_sw | b_sw), 16'h0000);
        check("reset rest", 16'({t_sw, relay, closing_o, op_oe}), 16'h0000);
        wr(3'h6, 16'h1004);
        bp_reset = 1'b1;
        tick(5);
        bp_reset = 1'b0;
        check("backplane reset", 16'(a_sw), 16'h0000);
        end_sim();
    end
endmodule : fet_mux_switch_control_tb

`default_nettype wire
